/* File: inc/nplc_map.vh */
// Purpose: constants for the flash program/lock sequencer
// Assumes: 25 MHz core clock
// Notes: op codes are {op_select_a, op_select_b, op_select_c, op_select_d}
`ifndef NPLC_MAP_VH
`define NPLC_MAP_VH
`define NPLC_CLK_KHZ 25000
`define NPLC_WRITE_US 1500
`define NPLC_PERASE_US 10000
`define NPLC_SERASE_US 16000
`define NPLC_MEM_SIZE 10240
`define NPLC_DATA_BASE 14'h2000
`define NPLC_ERASED 8'hFF
`define NPLC_ERASE_RD 8'h00
`define NPLC_LOCKED_RD 8'hFF
`define NPLC_SIG_ADDR0 14'h0030
`define NPLC_SIG_ADDR1 14'h0031
`define NPLC_OP_ERASE 4'h8
`define NPLC_OP_WRITE 4'h7
`define NPLC_OP_READ 4'h3
`define NPLC_OP_WLOCK 4'hA
`define NPLC_OP_RLOCK 4'hC
`define NPLC_OP_SIG 4'h0
`define NPLC_OP_FUSE 4'h6
`define NPLC_WL_LB1 7
`define NPLC_WL_LB2 6
`define NPLC_WL_LB3 5
`define NPLC_FUSE_BIT 0
`define NPLC_RL_LB1 2
`define NPLC_RL_LB2 3
`define NPLC_RL_LB3 4
`define NPLC_RL_FUSE 5
`define NPLC_SER_PFX 8'hAC
`define NPLC_SER_EN 8'h53
`define NPLC_SER_ERASE 3'h4
`define NPLC_SER_WLOCK 3'h7
`define NPLC_SER_RDCODE 3'h1
`define NPLC_SER_WRCODE 3'h2
`define NPLC_SER_RDDATA 3'h5
`define NPLC_SER_WRDATA 3'h6
`define NPLC_ST_INIT 2'h0
`define NPLC_ST_IDLE 2'h1
`define NPLC_ST_WRITE 2'h2
`define NPLC_ST_ERASE 2'h3
`endif

/* File: rtl/nplc_top.v */
// Purpose: program/erase/lock sequencer for code flash and data eeprom
// Assumes: serial frames arrive as whole 3-byte words on core_clk_i
// Notes: pins pass a two-flop synchroniser; array filled with ones after reset
//
// Behaviour
// - lock one programmed: capture access-select pin while reset pin high
// - lock bits cleared only by chip erase, parallel or serial
// - mode 2 blocks table reads of internal code and all array writes
// - mode 3 adds refusal of readback verify in both modes
// - mode 4 adds blocking of external execution
// - erased locations read as all ones
// - parallel map code low, data from 2000h; serial keeps two spaces
// - byte writes; serial write overwrites, erasing the byte first
// - one strobe pulse starts a self-timed byte or lock write
// - verify read returns the stored byte on the data port
// - while writing, last byte reads with bit seven inverted
// - after write, true data returned and next cycle accepted
// - progress pin low after strobe rises, high when write completes
// - readback refused once lock bits one and two set; lock bits readable in parallel
// - parallel erase after strobe held low 10 ms in erase mode
// - serial chip erase command self-timed about 16 ms
// - during chip erase serial reads return zero
// - fuse disables serial programming; changed only in parallel mode
// - signature bytes read at 030h and 031h with low selects
// - serial program or erase needs enable command after reset
// - serial erase frame prefix byte, pattern in byte two
`timescale 1ns/100ps
`include "nplc_map.vh"

module nplc_top #(
  parameter WRITE_CYC = (`NPLC_WRITE_US * `NPLC_CLK_KHZ) / 1000,
  parameter PERASE_CYC = (`NPLC_PERASE_US * `NPLC_CLK_KHZ) / 1000,
  parameter SERASE_CYC = (`NPLC_SERASE_US * `NPLC_CLK_KHZ) / 1000,
  // identity values are arbitrary
  parameter [7:0] SIG0 = 8'h5A,
  parameter [7:0] SIG1 = 8'hC3
)(
  input wire core_clk_i,
  input wire rst_i,
  input wire prog_reset_pin_i,
  input wire ext_access_prog_voltage_i,
  input wire program_store_strobe_n_i,
  input wire prog_strobe_i,
  input wire external_access_select_i,
  input wire op_select_a_i,
  input wire op_select_b_i,
  input wire op_select_c_i,
  input wire op_select_d_i,
  input wire [13:0] par_addr_i,
  input wire [7:0] par_data_i,
  input wire ser_frame_valid_i,
  input wire [7:0] ser_byte1_i,
  input wire [7:0] ser_byte2_i,
  input wire [7:0] ser_byte3_i,
  output reg [7:0] par_data_o,
  output reg par_data_oe_o,
  output reg progress_pin_o,
  output reg [7:0] ser_rdata_o,
  output reg ser_rdata_valid_o,
  output reg busy_o,
  output reg lock_bit_one_o,
  output reg lock_bit_two_o,
  output reg lock_bit_three_o,
  output reg serial_prog_disable_o,
  output reg ext_access_latch_o,
  output reg table_read_block_o,
  output reg ext_exec_block_o
);

localparam [14:0] MSZ = `NPLC_MEM_SIZE;

//////////////////////////////////////////////////////////////////////
// pin synchroniser
reg [30:0] sy1_r;
reg [30:0] sy2_r;
wire rstp_s;
wire vpp_s;
wire psn_s;
wire strb_s;
wire ea_s;
wire [3:0] op_s;
wire [13:0] adr_s;
wire [7:0] din_s;

always @(posedge core_clk_i)
begin
  sy1_r <= {prog_reset_pin_i, ext_access_prog_voltage_i, program_store_strobe_n_i,
            prog_strobe_i, external_access_select_i, op_select_a_i, op_select_b_i,
            op_select_c_i, op_select_d_i, par_addr_i, par_data_i};
  sy2_r <= sy1_r;
end

assign {rstp_s, vpp_s, psn_s, strb_s, ea_s, op_s, adr_s, din_s} = sy2_r;

//////////////////////////////////////////////////////////////////////
// state
reg [7:0] mem [0:`NPLC_MEM_SIZE-1];
reg [1:0] st_r;
reg [14:0] swp_r;
reg [31:0] cnt_r;
reg [31:0] era_len_r;
reg [31:0] plow_r;
reg strb_d_r;
reg lb1_r;
reg lb2_r;
reg lb3_r;
reg fuse_r;
reg ser_en_r;
reg par_wr_r;
reg [13:0] last_idx_r;
reg [7:0] last_dat_r;

wire par_mode = rstp_s & vpp_s & ~psn_s;
wire strb_rise = strb_s & ~strb_d_r;
wire idle = (st_r == `NPLC_ST_IDLE);
wire ser_ok = rstp_s & ~vpp_s & ~fuse_r & ser_frame_valid_i;
wire pfx = (ser_byte1_i == `NPLC_SER_PFX);
wire [2:0] sop = ser_byte1_i[2:0];
wire ser_rd = ~pfx & (sop == `NPLC_SER_RDCODE || sop == `NPLC_SER_RDDATA);
wire ser_wr = ~pfx & (sop == `NPLC_SER_WRCODE || sop == `NPLC_SER_WRDATA);
// serial spaces folded onto one array
wire [13:0] ser_idx = ser_byte1_i[2] ?
  (`NPLC_DATA_BASE | {3'h0, ser_byte1_i[5:3], ser_byte2_i}) :
  {1'b0, ser_byte1_i[7:3], ser_byte2_i};
wire [7:0] par_old = mem[adr_s];
wire par_in = ({1'b0, adr_s} < MSZ);

// read value for both ports
function [7:0] rd_val;
  input [13:0] idx;
  begin
    if (st_r == `NPLC_ST_ERASE)
      rd_val = `NPLC_ERASE_RD;
    // verify refused in mode 3 and above
    else if (lb1_r & lb2_r)
      rd_val = `NPLC_LOCKED_RD;
    else if ({1'b0, idx} >= MSZ)
      rd_val = `NPLC_ERASED;
    else if (st_r == `NPLC_ST_WRITE && idx == last_idx_r)
      rd_val = {~last_dat_r[7], last_dat_r[6:0]};
    else
      rd_val = mem[idx];
  end
endfunction

// lock state readable in parallel mode
function [7:0] lock_rd;
  input dummy;
  begin
    lock_rd = 8'h00;
    lock_rd[`NPLC_RL_LB1] = lb1_r;
    lock_rd[`NPLC_RL_LB2] = lb2_r;
    lock_rd[`NPLC_RL_LB3] = lb3_r;
    lock_rd[`NPLC_RL_FUSE] = fuse_r;
  end
endfunction

//////////////////////////////////////////////////////////////////////
// sequencer
always @(posedge core_clk_i)
begin
  if (rst_i)
  begin
    st_r <= `NPLC_ST_INIT;
    swp_r <= 15'h0000;
    cnt_r <= 32'h0000_0000;
    era_len_r <= 32'h0000_0001;
    plow_r <= 32'h0000_0000;
    // idle level of the strobe pin, no false edge after reset
    strb_d_r <= 1'b1;
    lb1_r <= 1'b0;
    lb2_r <= 1'b0;
    lb3_r <= 1'b0;
    fuse_r <= 1'b0;
    ser_en_r <= 1'b0;
    par_wr_r <= 1'b0;
    last_idx_r <= 14'h0000;
    last_dat_r <= `NPLC_ERASED;
    ext_access_latch_o <= 1'b0;
    progress_pin_o <= 1'b1;
    ser_rdata_o <= 8'h00;
    ser_rdata_valid_o <= 1'b0;
  end
  else
  begin
    strb_d_r <= strb_s;
    ser_rdata_valid_o <= 1'b0;
    // enable lost while reset pin low
    if (!rstp_s)
      ser_en_r <= 1'b0;
    if (rstp_s && lb1_r)
      ext_access_latch_o <= ea_s;
    if (ser_ok && ser_rd)
    begin
      ser_rdata_o <= rd_val(ser_idx);
      ser_rdata_valid_o <= 1'b1;
    end
    case (st_r)
      `NPLC_ST_INIT, `NPLC_ST_ERASE:
      begin
        if (swp_r < MSZ)
        begin
          mem[swp_r[13:0]] <= `NPLC_ERASED;
          swp_r <= swp_r + 15'h0001;
        end
        cnt_r <= cnt_r + 32'h0000_0001;
        // a held strobe counts again from zero, so a new erase follows another full hold
        plow_r <= 32'h0000_0000;
        if (swp_r == MSZ && (st_r == `NPLC_ST_INIT || cnt_r >= era_len_r))
          st_r <= `NPLC_ST_IDLE;
      end
      `NPLC_ST_WRITE:
      begin
        cnt_r <= cnt_r + 32'h0000_0001;
        if (cnt_r >= WRITE_CYC - 1)
        begin
          st_r <= `NPLC_ST_IDLE;
          if (par_wr_r)
            progress_pin_o <= 1'b1;
          par_wr_r <= 1'b0;
        end
      end
      default:
      begin
        cnt_r <= 32'h0000_0000;
        swp_r <= 15'h0000;
        // strobe held low in erase mode
        if (par_mode && op_s == `NPLC_OP_ERASE && !strb_s)
          plow_r <= plow_r + 32'h0000_0001;
        else
          plow_r <= 32'h0000_0000;
        if (par_mode && op_s == `NPLC_OP_ERASE && !strb_s && plow_r >= PERASE_CYC - 1)
        begin
          st_r <= `NPLC_ST_ERASE;
          era_len_r <= 32'h0000_0001;
          lb1_r <= 1'b0;
          lb2_r <= 1'b0;
          lb3_r <= 1'b0;
        end
        else if (par_mode && strb_rise)
        begin
          if (op_s == `NPLC_OP_WRITE && !lb1_r && par_in)
          begin
            // no auto erase, bits only clear
            mem[adr_s] <= par_old & din_s;
            last_idx_r <= adr_s;
            last_dat_r <= par_old & din_s;
            st_r <= `NPLC_ST_WRITE;
            par_wr_r <= 1'b1;
            progress_pin_o <= 1'b0;
          end
          else if (op_s == `NPLC_OP_WLOCK)
          begin
            lb1_r <= lb1_r | ~din_s[`NPLC_WL_LB1];
            lb2_r <= lb2_r | ~din_s[`NPLC_WL_LB2];
            lb3_r <= lb3_r | ~din_s[`NPLC_WL_LB3];
            st_r <= `NPLC_ST_WRITE;
            par_wr_r <= 1'b1;
            progress_pin_o <= 1'b0;
          end
          else if (op_s == `NPLC_OP_FUSE)
          begin
            // fuse changes in parallel mode only
            fuse_r <= ~din_s[`NPLC_FUSE_BIT];
            st_r <= `NPLC_ST_WRITE;
            par_wr_r <= 1'b1;
            progress_pin_o <= 1'b0;
          end
        end
        else if (ser_ok && pfx)
        begin
          if (ser_byte2_i == `NPLC_SER_EN)
            ser_en_r <= 1'b1;
          else if (ser_en_r && ser_byte2_i[2:0] == `NPLC_SER_ERASE)
          begin
            st_r <= `NPLC_ST_ERASE;
            era_len_r <= SERASE_CYC;
            lb1_r <= 1'b0;
            lb2_r <= 1'b0;
            lb3_r <= 1'b0;
          end
          else if (ser_en_r && ser_byte2_i[2:0] == `NPLC_SER_WLOCK)
          begin
            lb1_r <= lb1_r | ~ser_byte2_i[`NPLC_WL_LB1];
            lb2_r <= lb2_r | ~ser_byte2_i[`NPLC_WL_LB2];
            lb3_r <= lb3_r | ~ser_byte2_i[`NPLC_WL_LB3];
            st_r <= `NPLC_ST_WRITE;
          end
        end
        // writes blocked once lock one set
        else if (ser_ok && ser_wr && ser_en_r && !lb1_r)
        begin
          mem[ser_idx] <= ser_byte3_i;
          last_idx_r <= ser_idx;
          last_dat_r <= ser_byte3_i;
          st_r <= `NPLC_ST_WRITE;
        end
      end
    endcase
  end
end

//////////////////////////////////////////////////////////////////////
// outputs; one cycle behind the state they show
always @(posedge core_clk_i)
begin
  if (rst_i)
  begin
    par_data_o <= 8'h00;
    par_data_oe_o <= 1'b0;
    busy_o <= 1'b1;
    lock_bit_one_o <= 1'b0;
    lock_bit_two_o <= 1'b0;
    lock_bit_three_o <= 1'b0;
    serial_prog_disable_o <= 1'b0;
    table_read_block_o <= 1'b0;
    ext_exec_block_o <= 1'b0;
  end
  else
  begin
    busy_o <= ~idle;
    lock_bit_one_o <= lb1_r;
    lock_bit_two_o <= lb2_r;
    lock_bit_three_o <= lb3_r;
    serial_prog_disable_o <= fuse_r;
    // table reads blocked from mode 2
    table_read_block_o <= lb1_r;
    // external execution blocked in mode 4
    ext_exec_block_o <= lb1_r & lb2_r & lb3_r;
    par_data_oe_o <= par_mode & (op_s == `NPLC_OP_READ || op_s == `NPLC_OP_RLOCK ||
                                 op_s == `NPLC_OP_SIG);
    if (op_s == `NPLC_OP_READ)
      par_data_o <= rd_val(adr_s);
    else if (op_s == `NPLC_OP_RLOCK)
      par_data_o <= lock_rd(1'b0);
    else if (op_s == `NPLC_OP_SIG && adr_s == `NPLC_SIG_ADDR0)
      par_data_o <= SIG0;
    else if (op_s == `NPLC_OP_SIG && adr_s == `NPLC_SIG_ADDR1)
      par_data_o <= SIG1;
    else
      par_data_o <= `NPLC_ERASED;
  end
end

endmodule

/* File: verification/nplc_prog_model.sv */
// Purpose: parallel programmer on the mode pins
// Assumes: tasks entered just after a clock edge
// Notes: no erase before rewrite unless the bench asks
`timescale 1ns/100ps
module nplc_prog_model (
  input wire clk_i,
  input wire progress_pin_i,
  output reg vpp_o,
  output reg program_store_strobe_n_o,
  output reg strobe_o,
  output reg [3:0] op_o,
  output reg [13:0] addr_o,
  output reg [7:0] data_o
);
  integer timeouts;
  initial
  begin
    timeouts = 0;
    vpp_o = 1'b0;
    program_store_strobe_n_o = 1'b1;
    strobe_o = 1'b1;
    op_o = 4'hF;
    addr_o = 14'h0000;
    data_o = 8'h00;
  end
  ////////////////////////////////////////
  // op, address, voltage
  task setup(input [3:0] op, input [13:0] a, input [7:0] d);
  begin
    @(posedge clk_i);
    op_o <= op;
    addr_o <= a;
    data_o <= d;
    program_store_strobe_n_o <= 1'b0;
    vpp_o <= 1'b1;
    repeat (5) @(posedge clk_i);
  end
  endtask
  task pulse(input integer low_cyc);
  begin
    strobe_o <= 1'b0;
    repeat (low_cyc) @(posedge clk_i);
    strobe_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  end
  endtask
  task wait_ready;
    integer n;
  begin
    n = 0;
    while (progress_pin_i !== 1'b1 && n < 200)
    begin
      @(posedge clk_i);
      n = n + 1;
    end
    if (progress_pin_i !== 1'b1)
      timeouts = timeouts + 1;
    repeat (4) @(posedge clk_i);
  end
  endtask
  // released port shows the inverse, not a stale byte
  task release_pins;
  begin
    @(posedge clk_i);
    vpp_o <= 1'b0;
    program_store_strobe_n_o <= 1'b1;
    data_o <= ~data_o;
    repeat (5) @(posedge clk_i);
  end
  endtask
endmodule

/* File: verification/nplc_top_asserts.sv */
// Purpose: port checks of the program/lock sequencer
// Assumes: pins pass two sync flops
// Notes: bound in the bench top file
`timescale 1ns/100ps
module nplc_top_asserts #(
  parameter WRITE_CYC = 37500
)(
  input wire core_clk_i,
  input wire rst_i,
  input wire prog_reset_pin_i,
  input wire ext_access_prog_voltage_i,
  input wire prog_strobe_i,
  input wire ser_frame_valid_i,
  input wire [7:0] ser_byte1_i,
  input wire progress_pin_o,
  input wire ser_rdata_valid_o,
  input wire busy_o,
  input wire lock_bit_one_o,
  input wire lock_bit_two_o,
  input wire lock_bit_three_o,
  input wire serial_prog_disable_o,
  input wire table_read_block_o,
  input wire ext_exec_block_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  integer low_cnt;
  ////////////////////////////////////////
  // counts low time, too long for a repetition
  always @(posedge core_clk_i)
  begin
    if (rst_i || progress_pin_o)
      low_cnt <= 0;
    else
      low_cnt <= low_cnt + 1;
  end
  property p_rst_state;
    $fell(rst_i) |-> busy_o && progress_pin_o && !lock_bit_one_o && !serial_prog_disable_o;
  endproperty
  a_rst_state: assert property (p_rst_state) else $error("reset state wrong");
  property p_write_len;
    $rose(progress_pin_o) && !$past(rst_i) |-> low_cnt == WRITE_CYC;
  endproperty
  a_write_len: assert property (p_write_len) else $error("write length wrong");
  property p_write_cause;
    $fell(progress_pin_o) |-> $past(prog_strobe_i, 3) && $past(ext_access_prog_voltage_i, 3);
  endproperty
  a_write_cause: assert property (p_write_cause) else $error("busy without strobe");
  property p_ser_read;
    ser_frame_valid_i && ser_byte1_i[2:0] == 3'h1 && prog_reset_pin_i
      && !ext_access_prog_voltage_i && !serial_prog_disable_o |=> ser_rdata_valid_o;
  endproperty
  a_ser_read: assert property (p_ser_read) else $error("serial read lost");
  property p_valid_cause;
    ser_rdata_valid_o |-> $past(ser_frame_valid_i);
  endproperty
  a_valid_cause: assert property (p_valid_cause) else $error("stray read pulse");
  property p_lock_clear;
    $fell(lock_bit_one_o) && !$past(rst_i) |-> ##[0:3] busy_o;
  endproperty
  a_lock_clear: assert property (p_lock_clear) else $error("lock cleared without erase");
  property p_fuse_par;
    serial_prog_disable_o != $past(serial_prog_disable_o) && !$past(rst_i)
      |-> $past(ext_access_prog_voltage_i);
  endproperty
  a_fuse_par: assert property (p_fuse_par) else $error("fuse changed outside parallel");
  property p_table_blk;
    $stable(lock_bit_one_o) [*3] |-> $past(table_read_block_o) == lock_bit_one_o;
  endproperty
  a_table_blk: assert property (p_table_blk) else $error("table block wrong");
  property p_exec_blk;
    ($stable(lock_bit_one_o) && $stable(lock_bit_two_o) && $stable(lock_bit_three_o)) [*3]
      |-> $past(ext_exec_block_o) == (lock_bit_one_o && lock_bit_two_o && lock_bit_three_o);
  endproperty
  a_exec_blk: assert property (p_exec_blk) else $error("exec block wrong");
endmodule

/* File: verification/nplc_top_test.sv */
// Purpose: self-checking bench of the program/lock sequencer
// Assumes: shortened write and erase counts
// Notes: array model here, compared at reads of unlocked data, one of them taken mid-write with bit seven inverted
`timescale 1ns/100ps
module nplc_top_test;
  localparam WR = 20;
  localparam PE = 30;
  // identity values are arbitrary
  localparam [7:0] SIG0 = 8'h3D;
  localparam [7:0] SIG1 = 8'h96;
  reg core_clk_i;
  reg rst_i;
  reg rpin;
  reg ea_sel;
  reg sv;
  reg [7:0] b1, b2, b3;
  wire vpp, program_store_strobe_n, stb, prog, poe, srv, busy, l1, l2, l3, fuse, eal, tblk, xblk;
  wire [3:0] op;
  wire [13:0] addr;
  wire [7:0] wd, pdo, srd;
  integer errors, checks_done, seed, a, v, da;
  logic [7:0] mem [int];
  nplc_top #(.WRITE_CYC(WR), .PERASE_CYC(PE), .SERASE_CYC(50), .SIG0(SIG0), .SIG1(SIG1))
  u_nplc_top (.core_clk_i(core_clk_i), .rst_i(rst_i), .prog_reset_pin_i(rpin),
    .ext_access_prog_voltage_i(vpp), .program_store_strobe_n_i(program_store_strobe_n), .prog_strobe_i(stb),
    .external_access_select_i(ea_sel), .op_select_a_i(op[3]), .op_select_b_i(op[2]),
    .op_select_c_i(op[1]), .op_select_d_i(op[0]), .par_addr_i(addr), .par_data_i(wd),
    .ser_frame_valid_i(sv), .ser_byte1_i(b1), .ser_byte2_i(b2), .ser_byte3_i(b3),
    .par_data_o(pdo), .par_data_oe_o(poe), .progress_pin_o(prog), .ser_rdata_o(srd),
    .ser_rdata_valid_o(srv), .busy_o(busy), .lock_bit_one_o(l1), .lock_bit_two_o(l2),
    .lock_bit_three_o(l3), .serial_prog_disable_o(fuse), .ext_access_latch_o(eal),
    .table_read_block_o(tblk), .ext_exec_block_o(xblk));
  nplc_prog_model u_nplc_prog_model (.clk_i(core_clk_i), .progress_pin_i(prog), .vpp_o(vpp),
    .program_store_strobe_n_o(program_store_strobe_n), .strobe_o(stb), .op_o(op), .addr_o(addr), .data_o(wd));
  ////////////////////////////////////////
  function automatic [7:0] m(input integer k);
    m = mem.exists(k) ? mem[k] : 8'hFF;
  endfunction
  task chk(input string nm, input [7:0] e, input [7:0] g);
  begin
    checks_done = checks_done + 1;
    if (g !== e)
    begin
      errors = errors + 1;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  end
  endtask
  task ser(input [7:0] x, input [7:0] y, input [7:0] z);
  begin
    @(posedge core_clk_i);
    b1 <= x;
    b2 <= y;
    b3 <= z;
    sv <= 1'b1;
    @(posedge core_clk_i);
    sv <= 1'b0;
    // read pulse stands for this one cycle only
    #1;
  end
  endtask
  task sread(input [7:0] x, input [7:0] y, input [7:0] e);
  begin
    ser(x, y, 8'h00);
    chk("ser_valid", 8'h01, {7'h00, srv});
    chk("ser_data", e, srd);
  end
  endtask
  task pread(input [3:0] o, input [13:0] k, input [7:0] e);
  begin
    u_nplc_prog_model.setup(o, k, ~e);
    chk("par_data", e, pdo);
  end
  endtask
  task pwrite(input [3:0] o, input [13:0] k, input [7:0] d);
  begin
    u_nplc_prog_model.setup(o, k, d);
    u_nplc_prog_model.pulse(3);
  end
  endtask
  task wait_idle;
    integer n;
  begin
    n = 0;
    repeat (3) @(posedge core_clk_i);
    while (busy !== 1'b0 && n < 12000)
    begin
      @(posedge core_clk_i);
      n = n + 1;
    end
    if (busy !== 1'b0)
    begin
      errors = errors + 1;
      end_of_test;
    end
    repeat (4) @(posedge core_clk_i);
  end
  endtask
  task end_of_test;
  begin
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  initial
  begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  initial
  begin
    repeat (80000) @(posedge core_clk_i);
    errors = errors + 1;
    end_of_test;
  end
  initial
  begin
    rst_i = 1'b1;
    rpin = 1'b1;
    ea_sel = 1'b0;
    sv = 1'b0;
    b1 = 8'h00;
    b2 = 8'h00;
    b3 = 8'h00;
    errors = 0;
    checks_done = 0;
    seed = 83;
    repeat (4) @(posedge core_clk_i);
    rst_i <= 1'b0;
    wait_idle;
    a = $random(seed) & 32'h1FFF;
    v = $random(seed) & 32'hFF;
    da = 32'h2000 + (a & 32'h7FF);
    ser({a[12:8], 3'h2}, a[7:0], v[7:0]);
    wait_idle;
    sread({a[12:8], 3'h1}, a[7:0], 8'hFF);
    ser(8'hAC, 8'h53, 8'h00);
    ser({a[12:8], 3'h2}, a[7:0], v[7:0]);
    sread({a[12:8], 3'h1}, a[7:0], v[7:0] ^ 8'h80);
    chk("busy", 8'h01, {7'h00, busy});
    wait_idle;
    ser({a[12:8], 3'h2}, a[7:0], ~v[7:0]);
    wait_idle;
    mem[a] = ~v[7:0];
    sread({a[12:8], 3'h1}, a[7:0], m(a));
    ser({2'h0, a[10:8], 3'h6}, a[7:0], v[7:0]);
    wait_idle;
    mem[da] = v[7:0];
    pread(4'h3, a[13:0], m(a));
    pread(4'h3, da[13:0], m(da));
    chk("oe", 8'h01, {7'h00, poe});
    pread(4'h0, 14'h0030, SIG0);
    pread(4'h0, 14'h0031, SIG1);
    u_nplc_prog_model.release_pins;
    ser(8'hAC, 8'h53, 8'h00);
    ser(8'hAC, 8'h04, 8'h00);
    sread({a[12:8], 3'h1}, a[7:0], 8'h00);
    wait_idle;
    mem.delete();
    sread({2'h0, a[10:8], 3'h5}, a[7:0], m(da));
    pwrite(4'h7, 14'h2005, v[7:0]);
    chk("progress", 8'h00, {7'h00, prog});
    mem[32'h2005] = m(32'h2005) & v[7:0];
    pread(4'h3, 14'h2005, m(32'h2005) ^ 8'h80);
    u_nplc_prog_model.wait_ready;
    chk("progress", 8'h01, {7'h00, prog});
    pread(4'h3, 14'h2005, m(32'h2005));
    pwrite(4'h7, 14'h2005, ~v[7:0]);
    u_nplc_prog_model.wait_ready;
    mem[32'h2005] = m(32'h2005) & ~v[7:0];
    pread(4'h3, 14'h2005, m(32'h2005));
    pwrite(4'hA, 14'h0000, 8'h3F);
    u_nplc_prog_model.wait_ready;
    chk("table_block", 8'h01, {7'h00, tblk});
    pread(4'h3, 14'h2005, 8'hFF);
    u_nplc_prog_model.setup(4'hC, 14'h0000, 8'h00);
    chk("lock_read", 8'h0C, pdo & 8'h3C);
    ea_sel <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    chk("ea_latch", 8'h01, {7'h00, eal});
    pwrite(4'h7, 14'h0010, 8'h00);
    chk("refused", 8'h01, {7'h00, prog});
    pwrite(4'hA, 14'h0000, 8'h1F);
    u_nplc_prog_model.wait_ready;
    chk("exec_block", 8'h01, {7'h00, xblk});
    u_nplc_prog_model.setup(4'h8, 14'h0000, 8'h00);
    u_nplc_prog_model.pulse(PE + 4);
    wait_idle;
    mem.delete();
    chk("locks", 8'h00, {5'h00, l3, l2, l1});
    pread(4'h3, 14'h2005, m(32'h2005));
    pwrite(4'h6, 14'h0000, 8'hFE);
    u_nplc_prog_model.wait_ready;
    chk("fuse", 8'h01, {7'h00, fuse});
    u_nplc_prog_model.release_pins;
    ser(8'h01, 8'h00, 8'h00);
    chk("ser_off", 8'h00, {7'h00, srv});
    chk("ready_timeouts", 8'h00, u_nplc_prog_model.timeouts[7:0]);
    end_of_test;
  end
endmodule
bind nplc_top nplc_top_asserts #(.WRITE_CYC(WRITE_CYC)) u_nplc_top_asserts (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .prog_reset_pin_i(prog_reset_pin_i),
  .ext_access_prog_voltage_i(ext_access_prog_voltage_i), .prog_strobe_i(prog_strobe_i),
  .ser_frame_valid_i(ser_frame_valid_i), .ser_byte1_i(ser_byte1_i),
  .progress_pin_o(progress_pin_o), .ser_rdata_valid_o(ser_rdata_valid_o), .busy_o(busy_o),
  .lock_bit_one_o(lock_bit_one_o), .lock_bit_two_o(lock_bit_two_o),
  .lock_bit_three_o(lock_bit_three_o), .serial_prog_disable_o(serial_prog_disable_o),
  .table_read_block_o(table_read_block_o), .ext_exec_block_o(ext_exec_block_o));
